// [include/reiu_pkg.sv]
// Package: register offsets, field positions and reset values of the event unit
package reiu_pkg;
	localparam int ADDR_W = 11;
	localparam int DATA_W = 8;
	localparam logic [10:0] OFS_PIN_A_EN_LOW = 11'h3C7;
	localparam logic [10:0] OFS_PIN_A_EN_HIGH = 11'h3C8;
	localparam logic [10:0] OFS_PIN_B_EN_LOW = 11'h3C9;
	localparam logic [10:0] OFS_PIN_B_EN_HIGH = 11'h3CA;
	localparam logic [10:0] OFS_FLAGS_LOW = 11'h3CB;
	localparam logic [10:0] OFS_FLAGS_HIGH = 11'h3CC;
	// Low flag register bit positions
	localparam int BIT_READY = 1;
	localparam int BIT_WAKE = 2;
	localparam int BIT_IDLE = 3;
	localparam int BIT_COLD = 4;
	localparam int BIT_BATT = 5;
	// High flag register bit positions
	localparam int BIT_CCA = 0;
	localparam int BIT_SFD_RX = 1;
	localparam int BIT_SFD_TX = 2;
	localparam int BIT_FRM_RX = 3;
	localparam int BIT_FRM_TX = 4;
	// Implemented bits; reserved positions of the flag registers read as zero
	localparam logic [7:0] MASK_LOW = 8'h3E;
	localparam logic [7:0] MASK_HIGH = 8'h1F;
	// Enable reset values: only ready-after-sleep on the low registers
	localparam logic [7:0] EN_LOW_RESET = 8'h02;
	localparam logic [7:0] EN_HIGH_RESET = 8'h00;
	// Flags latched at power-up: ready, wake, idle, cold reset
	localparam logic [7:0] FLAGS_LOW_POWERUP = 8'h1E;
	localparam logic [7:0] ZERO8 = 8'h00;
endpackage

// [rtl/reiu_sync_edge.sv]
// Two-stage synchroniser with rising-edge pulse output
`timescale 1ns/1ns
`default_nettype none
module reiu_sync_edge #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Asynchronous levels in, one-cycle rise pulses out
	input wire logic [WIDTH-1:0] levelIn,
	output logic [WIDTH-1:0] levelSync,
	output logic [WIDTH-1:0] risePulse
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// First stage feeds only the second
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= levelIn;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Edge detection on settled stages only
	assign levelSync = stage2;
	assign risePulse = stage2 & ~stage3;
endmodule
`default_nettype wire

// [rtl/radio_event_interrupt_unit.sv]
// Event flag latching, per-pin enables and pin drive of the radio event unit
`timescale 1ns/1ns
`default_nettype none
module radio_event_interrupt_unit
	import reiu_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Register port from the serial control port
	input wire logic regWrite,
	input wire logic [reiu_pkg::ADDR_W-1:0] regAddr,
	input wire logic [reiu_pkg::DATA_W-1:0] regWriteData,
	output logic [reiu_pkg::DATA_W-1:0] regReadData,
	// Power and mode state
	input wire logic sleepMode,
	input wire logic wakeStrobe,
	input wire logic serial_stream_mode,
	input wire logic streamFrameSync,
	// Packet manager events, same clock
	input wire logic packetMode,
	input wire logic receiveState,
	input wire logic frameSentDone,
	input wire logic frameStored,
	input wire logic frameCheckOk,
	input wire logic delimSentDone,
	input wire logic delimFound,
	input wire logic channelCheckEnd,
	input wire logic controller_ready_flag,
	input wire logic portReadyFlag,
	// Hardware circuit levels, asynchronous
	input wire logic battLowLevel,
	input wire logic wakeTimerZero,
	// Pins and status
	output logic event_pin_a,
	output logic event_pin_a_oe,
	output logic event_pin_b,
	output logic event_pin_b_oe,
	output logic statusPending
);
	logic [7:0] pin_a_enable_low;
	logic [7:0] pin_a_enable_high;
	logic [7:0] pin_b_enable_low;
	logic [7:0] pin_b_enable_high;
	logic [7:0] event_flags_low;
	logic [7:0] event_flags_high;
	logic [7:0] setLow;
	logic [7:0] setHigh;
	logic [7:0] clrLow;
	logic [7:0] clrHigh;
	logic [1:0] asyncRise;
	logic prevCtrlReady;
	logic prevPortReady;
	logic wasAsleep;
	logic coldStart;
	logic next_pinA;
	logic next_pinB;

	// Battery and wake timer come from other circuits; synchronise them
	reiu_sync_edge #(
		.WIDTH(2)
	) u_sync (
		.clk_sys(clk_sys),
		.reset(reset),
		.levelIn({wakeTimerZero, battLowLevel}),
		.levelSync(),
		.risePulse(asyncRise)
	);

	// Rising-edge history of status word flags
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			prevCtrlReady <= 1'b0;
			prevPortReady <= 1'b0;
		end else begin
			prevCtrlReady <= controller_ready_flag;
			prevPortReady <= portReadyFlag;
		end
	end

	// Ready event only counts after a sleep exit; reset leaves it disarmed
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wasAsleep <= 1'b0;
		end else if (sleepMode) begin
			wasAsleep <= 1'b1;
		end else if (portReadyFlag && !prevPortReady) begin
			wasAsleep <= 1'b0;
		end
	end

	// One-shot marker for the power-up flag preset
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			coldStart <= 1'b1;
		end else begin
			coldStart <= 1'b0;
		end
	end

	// Event set terms
	always_comb begin
		setLow = ZERO8;
		setHigh = ZERO8;
		setHigh[BIT_FRM_TX] = packetMode && frameSentDone;
		setHigh[BIT_FRM_RX] = packetMode && frameStored
			&& frameCheckOk;
		setHigh[BIT_SFD_TX] = packetMode && delimSentDone;
		setHigh[BIT_SFD_RX] = receiveState && delimFound;
		setHigh[BIT_CCA] = channelCheckEnd;
		setLow[BIT_BATT] = asyncRise[0];
		setLow[BIT_IDLE] = controller_ready_flag && !prevCtrlReady;
		setLow[BIT_WAKE] = asyncRise[1];
		setLow[BIT_READY] = wasAsleep && portReadyFlag
			&& !prevPortReady;
	end

	// Write-one-to-clear decode; zeros leave flags alone
	always_comb begin
		clrLow = ZERO8;
		clrHigh = ZERO8;
		if (regWrite && regAddr == OFS_FLAGS_LOW) begin
			clrLow = regWriteData;
		end
		if (regWrite && regAddr == OFS_FLAGS_HIGH) begin
			clrHigh = regWriteData;
		end
	end

	// Sticky flags; a new event beats a same-cycle clear
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			event_flags_low <= ZERO8;
			event_flags_high <= ZERO8;
		end else if (coldStart) begin
			event_flags_low <= FLAGS_LOW_POWERUP;
			event_flags_high <= ZERO8;
		end else begin
			event_flags_low <= ((event_flags_low & ~clrLow) | setLow)
				& MASK_LOW;
			event_flags_high <= ((event_flags_high & ~clrHigh) | setHigh)
				& MASK_HIGH;
		end
	end

	// Enable registers; reset and wake restore the ready-only pattern
	always_ff @(posedge clk_sys) begin
		if (reset || wakeStrobe) begin
			pin_a_enable_low <= EN_LOW_RESET;
			pin_a_enable_high <= EN_HIGH_RESET;
			pin_b_enable_low <= EN_LOW_RESET;
			pin_b_enable_high <= EN_HIGH_RESET;
		end else if (regWrite) begin
			case (regAddr)
				OFS_PIN_A_EN_LOW: pin_a_enable_low <= regWriteData;
				OFS_PIN_A_EN_HIGH: pin_a_enable_high <= regWriteData;
				OFS_PIN_B_EN_LOW: pin_b_enable_low <= regWriteData;
				OFS_PIN_B_EN_HIGH: pin_b_enable_high <= regWriteData;
				default: begin
				end
			endcase
		end
	end

	// Registered read mux; unmapped addresses read zero
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			regReadData <= ZERO8;
		end else begin
			case (regAddr)
				OFS_PIN_A_EN_LOW: regReadData <= pin_a_enable_low;
				OFS_PIN_A_EN_HIGH: regReadData <= pin_a_enable_high;
				OFS_PIN_B_EN_LOW: regReadData <= pin_b_enable_low;
				OFS_PIN_B_EN_HIGH: regReadData <= pin_b_enable_high;
				OFS_FLAGS_LOW: regReadData <= event_flags_low;
				OFS_FLAGS_HIGH: regReadData <= event_flags_high;
				default: regReadData <= ZERO8;
			endcase
		end
	end

	// Masked OR of flags per pin
	always_comb begin
		next_pinA = |(event_flags_low & pin_a_enable_low)
			|| |(event_flags_high & pin_a_enable_high);
		next_pinB = |(event_flags_low & pin_b_enable_low)
			|| |(event_flags_high & pin_b_enable_high);
	end

	// Pin drive; pin B is handed to frame sync in stream mode
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			event_pin_a <= 1'b0;
			event_pin_b <= 1'b0;
			event_pin_a_oe <= 1'b0;
			event_pin_b_oe <= 1'b0;
		end else begin
			event_pin_a <= next_pinA;
			event_pin_b <= serial_stream_mode ? streamFrameSync
				: next_pinB;
			event_pin_a_oe <= !sleepMode;
			event_pin_b_oe <= !sleepMode;
		end
	end

	// Pending bit follows interrupts, not frame sync
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			statusPending <= 1'b0;
		end else begin
			statusPending <= next_pinA
				|| (next_pinB && !serial_stream_mode);
		end
	end

	// Assertions
	sequence clearWriteLow;
		regWrite && regAddr == OFS_FLAGS_LOW;
	endsequence
	sequence clearWriteHigh;
		regWrite && regAddr == OFS_FLAGS_HIGH;
	endsequence
	// Level rise, two sync stages, then the edge stage fires
	sequence battRise;
		!battLowLevel ##1 battLowLevel ##2 !coldStart;
	endsequence
	sequence wakeRise;
		!wakeTimerZero ##1 wakeTimerZero ##2 !coldStart;
	endsequence
	sequence sleepExitReady;
		sleepMode ##1 (!sleepMode && !portReadyFlag)
			##1 (portReadyFlag && !coldStart);
	endsequence

	flag_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
		clearWriteLow ##0 (!coldStart && regWriteData[BIT_IDLE]
		&& !setLow[BIT_IDLE]) |=> !event_flags_low[BIT_IDLE])
		else $error("flag not cleared by one");
	flag_keep_a: assert property (@(posedge clk_sys) disable iff (reset)
		clearWriteLow ##0 (!coldStart && !regWriteData[BIT_BATT]
		&& event_flags_low[BIT_BATT]) |=> event_flags_low[BIT_BATT])
		else $error("flag lost on zero write");
	flag_sticky_a: assert property (@(posedge clk_sys) disable iff (reset)
		event_flags_high[BIT_CCA] && !clrHigh[BIT_CCA]
		|=> event_flags_high[BIT_CCA])
		else $error("flag dropped without clear");
	frame_rx_a: assert property (@(posedge clk_sys) disable iff (reset)
		!coldStart && packetMode && frameStored && frameCheckOk
		|=> event_flags_high[BIT_FRM_RX])
		else $error("frame received not latched");
	idle_edge_a: assert property (@(posedge clk_sys) disable iff (reset)
		!coldStart && $rose(controller_ready_flag)
		|=> event_flags_low[BIT_IDLE])
		else $error("idle event missed");
	sleep_float_a: assert property (@(posedge clk_sys) disable iff (reset)
		sleepMode |=> !event_pin_a_oe && !event_pin_b_oe)
		else $error("pin driven in sleep");
	pin_or_a: assert property (@(posedge clk_sys) disable iff (reset)
		((|(event_flags_low & pin_a_enable_low)
		|| |(event_flags_high & pin_a_enable_high)) |=> event_pin_a)
		and (!(|(event_flags_low & pin_a_enable_low)
		|| |(event_flags_high & pin_a_enable_high)) |=> !event_pin_a))
		else $error("pin a not masked OR");
	stream_sync_a: assert property (@(posedge clk_sys) disable iff (reset)
		serial_stream_mode |=> event_pin_b == $past(streamFrameSync)
		&& statusPending == $past(next_pinA))
		else $error("pin b not frame sync");
	wake_enable_a: assert property (@(posedge clk_sys) disable iff (reset)
		wakeStrobe |=> pin_a_enable_low == EN_LOW_RESET
		&& pin_b_enable_high == EN_HIGH_RESET)
		else $error("enables not restored on wake");
	pending_a: assert property (@(posedge clk_sys) disable iff (reset)
		!serial_stream_mode && (next_pinA || next_pinB) |=> statusPending)
		else $error("pending flag missing");
	reserved_a: assert property (@(posedge clk_sys) disable iff (reset)
		(event_flags_high & ~MASK_HIGH) == ZERO8
		&& (event_flags_low & ~MASK_LOW) == ZERO8)
		else $error("reserved flag set");
	// Each qualified packet manager pulse lands in its own flag
	frame_tx_a: assert property (@(posedge clk_sys) disable iff (reset)
		!coldStart && packetMode && frameSentDone
		|=> event_flags_high[BIT_FRM_TX])
		else $error("frame sent not latched");
	delim_rx_a: assert property (@(posedge clk_sys) disable iff (reset)
		!coldStart && receiveState && delimFound
		|=> event_flags_high[BIT_SFD_RX])
		else $error("delimiter found not latched");
	chan_done_a: assert property (@(posedge clk_sys) disable iff (reset)
		!coldStart && channelCheckEnd |=> event_flags_high[BIT_CCA])
		else $error("channel check not latched");
	frame_bad_a: assert property (@(posedge clk_sys) disable iff (reset)
		!coldStart && !event_flags_high[BIT_FRM_RX]
		&& !(packetMode && frameStored && frameCheckOk)
		|=> !event_flags_high[BIT_FRM_RX])
		else $error("frame received without good frame");
	// Slow sources show up three edges late through the synchroniser
	batt_low_a: assert property (@(posedge clk_sys) disable iff (reset)
		battRise |=> event_flags_low[BIT_BATT])
		else $error("battery event missed");
	wake_timer_a: assert property (@(posedge clk_sys) disable iff (reset)
		wakeRise |=> event_flags_low[BIT_WAKE])
		else $error("wake timer event missed");
	ready_wake_a: assert property (@(posedge clk_sys) disable iff (reset)
		sleepExitReady |=> event_flags_low[BIT_READY])
		else $error("ready event missed after sleep");
	// Reset release: flag preset and ready-only enables
	flag_preset_a: assert property (@(posedge clk_sys) disable iff (reset)
		$fell(reset) |=> event_flags_low == FLAGS_LOW_POWERUP
		&& event_flags_high == ZERO8)
		else $error("power-up flags not preset");
	reset_en_a: assert property (@(posedge clk_sys) disable iff (reset)
		$fell(reset) |-> {pin_a_enable_low, pin_b_enable_low}
		== {EN_LOW_RESET, EN_LOW_RESET}
		&& {pin_a_enable_high, pin_b_enable_high} == {EN_HIGH_RESET, EN_HIGH_RESET})
		else $error("enables not ready-only after reset");
	en_write_a: assert property (@(posedge clk_sys) disable iff (reset)
		regWrite && !wakeStrobe && regAddr == OFS_PIN_B_EN_HIGH
		|=> pin_b_enable_high == $past(regWriteData))
		else $error("enable write lost");
	clear_high_a: assert property (@(posedge clk_sys) disable iff (reset)
		clearWriteHigh ##0 (!coldStart && regWriteData[BIT_FRM_TX]
		&& !(packetMode && frameSentDone)) |=> !event_flags_high[BIT_FRM_TX])
		else $error("high flag not cleared by one");
	pin_b_or_a: assert property (@(posedge clk_sys) disable iff (reset)
		(!serial_stream_mode && next_pinB |=> event_pin_b)
		and (!serial_stream_mode && !next_pinB |=> !event_pin_b))
		else $error("pin b not masked OR");
endmodule
`default_nettype wire

// [verification/reiu_host_model.sv]
// Host microcontroller model: register access and pin sensing
`timescale 1ns/1ns
`default_nettype none
module reiu_host_model
	import reiu_pkg::*;
(
	// Clock
	input wire logic clk_sys,
	// Register port towards the device
	output logic regWrite,
	output logic [reiu_pkg::ADDR_W-1:0] regAddr,
	output logic [reiu_pkg::DATA_W-1:0] regWriteData,
	input wire logic [reiu_pkg::DATA_W-1:0] regReadData,
	// Event pins with their enables, and levels seen by the host
	input wire logic event_pin_a,
	input wire logic event_pin_a_oe,
	input wire logic event_pin_b,
	input wire logic event_pin_b_oe,
	output logic pinLevelA,
	output logic pinLevelB
);
	// Host pull-downs hold floating pins low
	assign pinLevelA = event_pin_a_oe ? event_pin_a : 1'b0;
	assign pinLevelB = event_pin_b_oe ? event_pin_b : 1'b0;
	// Bus idle from time zero
	initial begin
		regWrite = 1'b0;
		regAddr = '0;
		regWriteData = '0;
	end
	// Strobe spans exactly one rising edge, then an idle cycle follows
	task automatic writeReg(input logic [10:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		regWrite = 1'b1;
		regAddr = a;
		regWriteData = d;
		@(negedge clk_sys);
		regWrite = 1'b0;
	endtask
	// Read data is registered, so sample one cycle after the address
	task automatic readReg(input logic [10:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		regAddr = a;
		@(negedge clk_sys);
		d = regReadData;
	endtask
	// Start-up: drop every latched flag
	task automatic clearAll();
		writeReg(OFS_FLAGS_LOW, 8'hFF);
		writeReg(OFS_FLAGS_HIGH, 8'hFF);
	endtask
	// Reserved positions are never enabled
	task automatic setEnables(input logic [7:0] al, ah, bl, bh);
		writeReg(OFS_PIN_A_EN_LOW, al & MASK_LOW);
		writeReg(OFS_PIN_A_EN_HIGH, ah & MASK_HIGH);
		writeReg(OFS_PIN_B_EN_LOW, bl & MASK_LOW);
		writeReg(OFS_PIN_B_EN_HIGH, bh & MASK_HIGH);
	endtask
endmodule
`default_nettype wire

// [verification/radio_event_interrupt_unit_tb.sv]
// Self-checking bench of the radio event interrupt unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin checkCount++; if ((got) !== (exp)) begin \
	errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
	end end
module radio_event_interrupt_unit_tb;
	import reiu_pkg::*;
	logic clk_sys, reset, regWrite, sleepMode, wakeStrobe, streamFrameSync;
	logic serial_stream_mode, packetMode, receiveState, frameSentDone;
	logic frameStored, frameCheckOk, delimSentDone, delimFound;
	logic channelCheckEnd, controller_ready_flag, portReadyFlag, ctlPrev;
	logic battLowLevel, wakeTimerZero, statusPending, pinLevelA, pinLevelB;
	logic event_pin_a, event_pin_a_oe, event_pin_b, event_pin_b_oe;
	logic [10:0] regAddr;
	logic [7:0] regWriteData, regReadData, expL, expH, eAL, eAH, eBL, eBH;
	logic [31:0] rnd;
	logic [7:0] rdBack;
	int errors, checkCount;
	radio_event_interrupt_unit radio_event_interrupt_unit_inst (.clk_sys,
		.reset, .regWrite, .regAddr, .regWriteData, .regReadData, .sleepMode,
		.wakeStrobe, .serial_stream_mode, .streamFrameSync, .packetMode,
		.receiveState, .frameSentDone, .frameStored, .frameCheckOk,
		.delimSentDone, .delimFound, .channelCheckEnd, .controller_ready_flag,
		.portReadyFlag, .battLowLevel, .wakeTimerZero, .event_pin_a,
		.event_pin_a_oe, .event_pin_b, .event_pin_b_oe, .statusPending);
	reiu_host_model reiu_host_model_inst (.clk_sys, .regWrite, .regAddr,
		.regWriteData, .regReadData, .event_pin_a, .event_pin_a_oe,
		.event_pin_b, .event_pin_b_oe, .pinLevelA, .pinLevelB);
	// 125 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// Random source with a fixed start
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Expected pin: any flag whose enable is set
	function automatic logic pinExp(input logic [7:0] el, eh);
		return |((expL & el) | (expH & eh));
	endfunction
	// Every mapped register against the expected image
	task automatic chkRegs();
		logic [7:0] d;
		reiu_host_model_inst.readReg(OFS_FLAGS_LOW, d);
		`CHK(d, expL)
		reiu_host_model_inst.readReg(OFS_FLAGS_HIGH, d);
		`CHK(d, expH)
		reiu_host_model_inst.readReg(OFS_PIN_A_EN_LOW, d);
		`CHK(d, eAL)
		reiu_host_model_inst.readReg(OFS_PIN_A_EN_HIGH, d);
		`CHK(d, eAH)
		reiu_host_model_inst.readReg(OFS_PIN_B_EN_LOW, d);
		`CHK(d, eBL)
		reiu_host_model_inst.readReg(OFS_PIN_B_EN_HIGH, d);
		`CHK(d, eBH)
	endtask
	// One-cycle event pulses with random qualifying levels
	task automatic fireEvents(input logic [31:0] r);
		@(negedge clk_sys);
		{channelCheckEnd, delimFound, delimSentDone, frameStored,
			frameSentDone, frameCheckOk, receiveState, packetMode} = r[7:0];
		controller_ready_flag = r[8];
		expH[BIT_FRM_TX] |= r[0] & r[3];
		expH[BIT_FRM_RX] |= r[0] & r[2] & r[4];
		expH[BIT_SFD_TX] |= r[0] & r[5];
		expH[BIT_SFD_RX] |= r[1] & r[6];
		expH[BIT_CCA] |= r[7];
		expL[BIT_IDLE] |= r[8] & !ctlPrev;
		ctlPrev = r[8];
		@(negedge clk_sys);
		{channelCheckEnd, delimFound, delimSentDone, frameStored} = '0;
		frameSentDone = 1'b0;
	endtask
	// Verdict, reached by the main sequence or the watchdog
	task automatic testDone();
		$display("checks=%0d mismatches=%0d", checkCount, errors);
		if (errors == 0 && checkCount > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Watchdog: the tests need well under 3000 cycles
	initial begin
		#160000;
		errors++;
		testDone();
	end
	// Main sequence
	initial begin
		{sleepMode, wakeStrobe, serial_stream_mode, streamFrameSync, ctlPrev,
			packetMode, receiveState, frameSentDone, frameStored, frameCheckOk,
			delimSentDone, delimFound, channelCheckEnd, controller_ready_flag,
			portReadyFlag, battLowLevel, wakeTimerZero} = '0;
		reset = 1'b1;
		errors = 0;
		checkCount = 0;
		rnd = 32'hE26A6CB3;
		repeat (12) @(negedge clk_sys);
		reset = 1'b0;
		repeat (3) @(negedge clk_sys);
		expL = FLAGS_LOW_POWERUP;
		expH = ZERO8;
		{eAL, eBL, eAH, eBH} = {EN_LOW_RESET, EN_LOW_RESET, ZERO8, ZERO8};
		chkRegs();
		`CHK({pinLevelA, pinLevelB, statusPending}, 3'b111)
		reiu_host_model_inst.readReg(11'h3CD, rdBack);
		`CHK(rdBack, ZERO8)
		$display("test reset done");
		reiu_host_model_inst.writeReg(OFS_FLAGS_LOW, ZERO8);
		chkRegs();
		reiu_host_model_inst.writeReg(OFS_FLAGS_LOW, 8'h08);
		expL = 8'h16;
		chkRegs();
		reiu_host_model_inst.clearAll();
		expL = ZERO8;
		chkRegs();
		$display("test clear done");
		// Random enables, events and clears
		for (int i = 0; i < 40; i++) begin
			rnd = lfsr(rnd);
			{eBH, eBL, eAH, eAL} = rnd & {MASK_HIGH, MASK_LOW, MASK_HIGH, MASK_LOW};
			reiu_host_model_inst.setEnables(eAL, eAH, eBL, eBH);
			rnd = lfsr(rnd);
			fireEvents(rnd);
			repeat (2) @(negedge clk_sys);
			`CHK(pinLevelA, pinExp(eAL, eAH))
			`CHK(pinLevelB, pinExp(eBL, eBH))
			`CHK(statusPending, pinExp(eAL, eAH) | pinExp(eBL, eBH))
			chkRegs();
			rnd = lfsr(rnd);
			reiu_host_model_inst.writeReg(OFS_FLAGS_HIGH, rnd[7:0]);
			reiu_host_model_inst.writeReg(OFS_FLAGS_LOW, rnd[15:8]);
			expH &= ~rnd[7:0];
			expL &= ~rnd[15:8];
			chkRegs();
		end
		$display("test random done");
		// Battery-low and wake-timer levels rise together
		battLowLevel = 1'b1;
		wakeTimerZero = 1'b1;
		repeat (6) @(negedge clk_sys);
		expL |= 8'h24;
		chkRegs();
		{battLowLevel, wakeTimerZero} = 2'b00;
		$display("test async done");
		serial_stream_mode = 1'b1;
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			streamFrameSync = rnd[0];
			repeat (2) @(negedge clk_sys);
			`CHK(event_pin_b, rnd[0])
			`CHK(statusPending, pinExp(eAL, eAH))
			`CHK(pinLevelA, pinExp(eAL, eAH))
		end
		serial_stream_mode = 1'b0;
		$display("test stream done");
		sleepMode = 1'b1;
		repeat (2) @(negedge clk_sys);
		`CHK({event_pin_a_oe, event_pin_b_oe}, 2'b00)
		sleepMode = 1'b0;
		wakeStrobe = 1'b1;
		@(negedge clk_sys);
		wakeStrobe = 1'b0;
		portReadyFlag = 1'b1;
		repeat (4) @(negedge clk_sys);
		{eAL, eBL, eAH, eBH} = {EN_LOW_RESET, EN_LOW_RESET, ZERO8, ZERO8};
		expL[BIT_READY] = 1'b1;
		chkRegs();
		`CHK({event_pin_a_oe, event_pin_b_oe}, 2'b11)
		`CHK({pinLevelA, pinLevelB}, 2'b11)
		$display("test sleep done");
		testDone();
	end
endmodule
`default_nettype wire
